// ---- hw/lcdcfg_consts.vh ----
// How it works
// [R1] Contrast code bits 2-0 select ladder resistance; zero shorts, n gives n/7.
// [R2] Contrast register bits 7-3 always read as zero.
// [R3] Segment enable bit set hands its pin to the segment driver.
// [R4] Pixel bit one drives the pixel dark, zero drives it clear.
// [R5] Two-bit clock select picks system divider, Timer1 oscillator or low-frequency oscillator.
// [R6] System clock source passes a fixed divide-by-256 stage.
// [R7] Software enables the Timer1 oscillator before selecting it.
// [R8] The 31 kHz internal oscillator is usable as third source.
// [R9] Timer1 and low-frequency sources keep running while the core sleeps.
// [R10] A 4-bit counter divides the selected clock as prescaler.
// [R11] Prescaler counter is hidden; only the prescale field sets its ratio.
// [R12] Prescale field values select ratios 1:1 through 1:16.
// [R13] Static, half and one-third bias are selectable.
// [R14] Half bias bypasses the middle ladder resistor.
// [R15] Ladder is off whenever the module is inactive.
// [R16] Ladder offers low, medium, high power and fully off.
// [R17] Pixel bits of disabled segments do not affect the pin.
// [R18] Prescaler output is the frame clock sequencing commons and segments.
`ifndef LCDCFG_CONSTS_VH
`define LCDCFG_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LCDCFG_OFS_CONTROL 8'h00
`define LCDCFG_OFS_PRESCALE 8'h04
`define LCDCFG_OFS_CONTRAST 8'h08
`define LCDCFG_OFS_SEGEN 8'h0C
`define LCDCFG_OFS_PIXEL0 8'h10
`define LCDCFG_OFS_PIXEL1 8'h14
`define LCDCFG_OFS_PIXEL2 8'h18
`define LCDCFG_OFS_PIXEL3 8'h1C
`define LCDCFG_OFS_STATUS 8'h20
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define LCDCFG_CTL_EN 0
`define LCDCFG_CTL_CS_LO 1
`define LCDCFG_CTL_CS_HI 2
`define LCDCFG_CTL_SLEEPEN 3
`define LCDCFG_CTL_BIAS_LO 4
`define LCDCFG_CTL_BIAS_HI 5
`define LCDCFG_CTL_PWR_LO 6
`define LCDCFG_CTL_PWR_HI 7
`define LCDCFG_CS_SYS 2'h0
`define LCDCFG_CS_T1 2'h1
`define LCDCFG_CS_LF 2'h2
`define LCDCFG_BIAS_STATIC 2'h0
`define LCDCFG_BIAS_HALF 2'h1
`define LCDCFG_BIAS_THIRD 2'h2
`define LCDCFG_PWR_OFF 2'h0
`define LCDCFG_PWR_LOW 2'h1
`define LCDCFG_PWR_MED 2'h2
`define LCDCFG_PWR_HIGH 2'h3
`define LCDCFG_CONTRAST_W 3
`define LCDCFG_CONTROL_RST 8'h00
`define LCDCFG_CONTRAST_RST 8'h00
`define LCDCFG_SEGEN_RST 8'h00
`define LCDCFG_PIXEL_RST 8'h00
`define LCDCFG_SYSDIV 256
`define LCDCFG_SYSDIV_W 8
`define LCDCFG_NCOM 4
`endif

// ---- hw/lcdcfg_prescaler.v ----
`timescale 1ns/1ns
`include "lcdcfg_consts.vh"
module lcdcfg_prescaler (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Control
	input wire run,
	input wire src_tick,
	input wire [3:0] ratio,
	// Frame tick
	output reg frame_tick
);
	reg [3:0] count;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// [R10] four-bit divider
	// [R12] ratio field value n gives 1:(n+1)
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 4'h0;
			frame_tick <= 1'b0;
		end else begin
			frame_tick <= 1'b0;
			if (!run) begin
				count <= 4'h0;
			end else if (src_tick) begin
				if (count >= ratio) begin
					count <= 4'h0;
					frame_tick <= 1'b1;
				end else begin
					count <= count + 4'h1;
				end
			end
		end
	end
endmodule

// ---- hw/lcdcfg_top.v ----
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "lcdcfg_consts.vh"
module lcdcfg_top (
	// Clock and reset
	input wire CLK,
	input wire ARST_N,
	// Wishbone slave
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	// Clock sources, already synchronous edge markers
	input wire T1_TICK,
	input wire LF_TICK,
	input wire CORE_SLEEP,
	// Ordinary port data for non-segment pins
	input wire [7:0] PORT_OUT,
	// Pins and analog controls
	output reg [7:0] PIN_OUT,
	output reg [7:0] SEG_FUNC,
	output reg [7:0] SEG_OUT,
	output reg [3:0] COM_OUT,
	output reg [2:0] CONTRAST_CODE,
	output reg CONTRAST_SHORT,
	output reg [1:0] LADDER_PWR,
	output reg LADDER_MID_BYPASS,
	output reg [1:0] BIAS_MODE,
	output reg FRAME_CLK
);
	reg [7:0] display_control_reg;
	reg [3:0] prescale_field;
	reg [2:0] contrast_control;
	reg [7:0] segment_enable;
	reg [7:0] pixel_data [0:`LCDCFG_NCOM-1];
	reg [`LCDCFG_SYSDIV_W-1:0] sys_div;
	reg [1:0] com_idx;
	reg phase;
	reg [31:0] next_rdata;
	reg src_tick;
	reg module_active_flag;
	wire frame_tick;
	wire [1:0] clk_sel;
	wire [1:0] bias_sel;
	wire [1:0] com_sel;
	wire sleep_ok;
	wire wr;
	wire run;

	assign clk_sel = display_control_reg[`LCDCFG_CTL_CS_HI:`LCDCFG_CTL_CS_LO];
	assign bias_sel = display_control_reg[`LCDCFG_CTL_BIAS_HI:`LCDCFG_CTL_BIAS_LO];
	// Static bias uses common 0 at once, not only after the counter wraps back
	assign com_sel = (bias_sel == `LCDCFG_BIAS_STATIC) ? 2'h0 : com_idx;
	assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O & WB_SEL_I[0];
	// [R9] system source ticks stop in sleep, the other two keep going
	assign sleep_ok = ~CORE_SLEEP | (clk_sel != `LCDCFG_CS_SYS);
	assign run = display_control_reg[`LCDCFG_CTL_EN] & sleep_ok;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// [R11] counter itself is not mapped, only its ratio field
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			display_control_reg <= `LCDCFG_CONTROL_RST;
			prescale_field <= 4'h0;
			contrast_control <= 3'h0;
			segment_enable <= `LCDCFG_SEGEN_RST;
		end else if (wr) begin
			case (WB_ADR_I)
			`LCDCFG_OFS_CONTROL: display_control_reg <= WB_DAT_I[7:0];
			`LCDCFG_OFS_PRESCALE: prescale_field <= WB_DAT_I[3:0];
			// [R1] three-bit contrast code
			`LCDCFG_OFS_CONTRAST: contrast_control <= WB_DAT_I[2:0];
			`LCDCFG_OFS_SEGEN: segment_enable <= WB_DAT_I[7:0];
			default: ;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < `LCDCFG_NCOM; g = g + 1) begin : g_pix
			always @(posedge CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					pixel_data[g] <= `LCDCFG_PIXEL_RST;
				end else if (wr && WB_ADR_I == `LCDCFG_OFS_PIXEL0 + 8'h04 * g) begin
					pixel_data[g] <= WB_DAT_I[7:0];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always @* begin
		next_rdata = 32'h0000_0000;
		case (WB_ADR_I)
		`LCDCFG_OFS_CONTROL: next_rdata = {24'h0, display_control_reg};
		`LCDCFG_OFS_PRESCALE: next_rdata = {28'h0, prescale_field};
		// [R2] upper five bits read zero
		`LCDCFG_OFS_CONTRAST: next_rdata = {29'h0, contrast_control};
		`LCDCFG_OFS_SEGEN: next_rdata = {24'h0, segment_enable};
		`LCDCFG_OFS_PIXEL0: next_rdata = {24'h0, pixel_data[0]};
		`LCDCFG_OFS_PIXEL1: next_rdata = {24'h0, pixel_data[1]};
		`LCDCFG_OFS_PIXEL2: next_rdata = {24'h0, pixel_data[2]};
		`LCDCFG_OFS_PIXEL3: next_rdata = {24'h0, pixel_data[3]};
		`LCDCFG_OFS_STATUS: next_rdata = {29'h0, phase, com_idx[0], module_active_flag};
		default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Single-wait-state answer; unmapped reads return zero, writes are dropped
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
			WB_DAT_O <= next_rdata;
		end
	end

	// ----------------------------------------
	// Clock source selection
	// ----------------------------------------
	// [R5] [R6] [R8] three sources, system path fixed at 256
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sys_div <= {`LCDCFG_SYSDIV_W{1'b0}};
			src_tick <= 1'b0;
		end else begin
			sys_div <= sys_div + {{(`LCDCFG_SYSDIV_W-1){1'b0}}, 1'b1};
			case (clk_sel)
			`LCDCFG_CS_SYS: src_tick <= (sys_div == {`LCDCFG_SYSDIV_W{1'b1}}) & ~CORE_SLEEP;
			// [R7] oscillator enable belongs to the timer; we only take its ticks
			`LCDCFG_CS_T1: src_tick <= T1_TICK;
			`LCDCFG_CS_LF: src_tick <= LF_TICK;
			default: src_tick <= 1'b0;
			endcase
		end
	end

	lcdcfg_prescaler u_presc (
		.clk(CLK),
		.arst_n(ARST_N),
		.run(run),
		.src_tick(src_tick),
		.ratio(prescale_field),
		.frame_tick(frame_tick)
	);

	// ----------------------------------------
	// Frame sequencing and pin drive
	// ----------------------------------------
	// [R18] each frame tick advances phase; outside static bias every second tick also advances common
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			com_idx <= 2'h0;
			phase <= 1'b0;
			module_active_flag <= 1'b0;
			FRAME_CLK <= 1'b0;
		end else begin
			module_active_flag <= display_control_reg[`LCDCFG_CTL_EN];
			if (frame_tick) begin
				FRAME_CLK <= ~FRAME_CLK;
				phase <= ~phase;
				if (phase) begin
					if (bias_sel == `LCDCFG_BIAS_STATIC) begin
						com_idx <= 2'h0;
					end else begin
						com_idx <= com_idx + 2'h1;
					end
				end
			end
		end
	end

	// Segment outputs alternate polarity each phase to keep the glass DC-free
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PIN_OUT <= 8'h00;
			SEG_FUNC <= 8'h00;
			SEG_OUT <= 8'h00;
			COM_OUT <= 4'h0;
			CONTRAST_CODE <= 3'h0;
			CONTRAST_SHORT <= 1'b1;
			LADDER_PWR <= `LCDCFG_PWR_OFF;
			LADDER_MID_BYPASS <= 1'b0;
			BIAS_MODE <= `LCDCFG_BIAS_STATIC;
		end else begin
			// [R3] enabled pins go to the segment driver
			SEG_FUNC <= segment_enable;
			// [R4] [R17] pixel drive only on enabled pins
			SEG_OUT <= segment_enable & (pixel_data[com_sel] ^ {8{phase}});
			PIN_OUT <= (segment_enable & (pixel_data[com_sel] ^ {8{phase}}))
				| (~segment_enable & PORT_OUT);
			COM_OUT <= module_active_flag ? ((4'h1 << com_sel) ^ {4{phase}}) : 4'h0;
			CONTRAST_CODE <= contrast_control;
			// [R1] code zero shorts the ladder
			CONTRAST_SHORT <= (contrast_control == 3'h0);
			// [R13] bias type forwarded
			BIAS_MODE <= bias_sel;
			// [R14] middle resistor out in half bias
			LADDER_MID_BYPASS <= (bias_sel == `LCDCFG_BIAS_HALF);
			// [R15] [R16] inactive module forces ladder off
			LADDER_PWR <= module_active_flag ?
				display_control_reg[`LCDCFG_CTL_PWR_HI:`LCDCFG_CTL_PWR_LO] : `LCDCFG_PWR_OFF;
		end
	end
endmodule

// ---- bench/lcdcfg_chk.sv ----
`timescale 1ns/1ns
module lcdcfg_chk (
	// Clock and reset
	input wire CLK,
	input wire ARST_N,
	// Bus
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	input wire [31:0] WB_DAT_O,
	input wire WB_ACK_O,
	// Pins and analog
	input wire [7:0] PORT_OUT,
	input wire [7:0] PIN_OUT,
	input wire [7:0] SEG_FUNC,
	input wire [7:0] SEG_OUT,
	input wire [3:0] COM_OUT,
	input wire [2:0] CONTRAST_CODE,
	input wire CONTRAST_SHORT,
	input wire [1:0] LADDER_PWR,
	input wire LADDER_MID_BYPASS,
	input wire [1:0] BIAS_MODE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// Pins only follow the port after one registered cycle
	logic up;
	wire [2:0] wd = WB_DAT_I[2:0];
	wire wr_c = WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h08 && WB_SEL_I[0];
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			up <= 1'b0;
		end else begin
			up <= 1'b1;
		end
	end
	property p_short; CONTRAST_SHORT == (CONTRAST_CODE == 3'h0); endproperty
	a_short: assert property (p_short) else $error("short flag");
	property p_code; wr_c |=> CONTRAST_CODE == $past(wd); endproperty
	a_code: assert property (p_code) else $error("contrast code");
	property p_rd; WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h08 |-> WB_DAT_O[31:3] == 0; endproperty
	a_rd: assert property (p_rd) else $error("contrast upper bits");
	property p_pin; up |-> PIN_OUT == (SEG_OUT & SEG_FUNC | $past(PORT_OUT) & ~SEG_FUNC); endproperty
	a_pin: assert property (p_pin) else $error("pin mux");
	property p_mask; (SEG_OUT & ~SEG_FUNC) == 8'h00; endproperty
	a_mask: assert property (p_mask) else $error("disabled segment");
	property p_byp; LADDER_MID_BYPASS == (BIAS_MODE == 2'h1); endproperty
	a_byp: assert property (p_byp) else $error("bypass");
	property p_off; COM_OUT == 4'h0 |-> LADDER_PWR == 2'h0; endproperty
	a_off: assert property (p_off) else $error("ladder on");
	property p_stat; BIAS_MODE == 2'h0 && COM_OUT != 4'h0 |-> COM_OUT inside {4'h1, 4'hE}; endproperty
	a_stat: assert property (p_stat) else $error("static common");
	c_stat: cover property (BIAS_MODE == 2'h0 && COM_OUT == 4'hE);
	c_wr: cover property (wr_c);
	c_byp: cover property (LADDER_MID_BYPASS);
	c_high: cover property (LADDER_PWR == 2'h3);
endmodule

// ---- bench/lcdcfg_glass.sv ----
`timescale 1ns/1ns
module lcdcfg_glass (
	// Glass lines
	input wire clk,
	input wire [7:0] seg,
	input wire [3:0] com,
	// Dark pixels on common 0
	output logic [7:0] lit
);
	// Only the unswapped phase is read, so no inversion guess is made
	always @(posedge clk) begin
		if (com == 4'h1) begin
			lit <= seg;
		end
	end
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ns
module tb;
	logic clk, arst_n, cyc, stb, we, t1, lf, slp, ack, cs, byp, fc;
	logic [7:0] adr, port, pin, sf, so, d, lit, pix, en;
	logic [3:0] sel, com;
	logic [31:0] dat, rd;
	logic [2:0] cc;
	logic [1:0] ldr, bm;
	logic [31:0] q[$];
	integer failures = 0, checks_done = 0, seed = 9773, i, n, tk = 0;
	lcdcfg_top dut_u (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rd),
		.WB_ACK_O(ack), .T1_TICK(t1), .LF_TICK(lf), .CORE_SLEEP(slp), .PORT_OUT(port),
		.PIN_OUT(pin), .SEG_FUNC(sf), .SEG_OUT(so), .COM_OUT(com), .CONTRAST_CODE(cc),
		.CONTRAST_SHORT(cs), .LADDER_PWR(ldr), .LADDER_MID_BYPASS(byp), .BIAS_MODE(bm),
		.FRAME_CLK(fc));
	lcdcfg_glass glass_u (.clk(clk), .seg(so), .com(com), .lit(lit));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Timer1 oscillator runs from the start, before it is selected
	always @(posedge clk) begin
		tk <= tk + 1;
		t1 <= (tk % 2 == 0);
		lf <= (tk % 4 == 0);
		port <= $random(seed);
	end
	task check(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task summarize;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task wb(input logic [7:0] a, input logic w, input logic [7:0] v, e);
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, v};
		if (!w) q.push_back({24'h0, e});
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			summarize;
		end
		{cyc, stb} <= 2'b00;
	endtask
	always @(posedge clk) begin
		if (ack === 1'b1 && !we && q.size() > 0) check("rdata", rd, q.pop_front());
	end
	task frame(input logic [7:0] ctl, ps, input integer per);
		integer k, c;
		logic f;
		wb(8'h04, 1'b1, ps, 8'h00);
		wb(8'h00, 1'b1, ctl, 8'h00);
		for (k = 0; k < 3; k++) begin
			c = 0;
			f = fc;
			do begin
				@(posedge clk);
				c++;
			end while (fc === f && c < 5000);
			if (c >= 5000) begin
				failures++;
				summarize;
			end
		end
		check("frame", c, per);
	endtask
	initial begin
		{cyc, stb, we, slp, arst_n, adr, dat} = 0;
		sel = 4'hF;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		check("short", cs, 1);
		check("ladder", ldr, 0);
		// Reset values, status and an unmapped word
		for (i = 0; i <= 36; i += 4) wb(i[7:0], 1'b0, 8'h00, 8'h00);
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			wb(8'h08, 1'b1, {d[7:3], i[2:0]}, 8'h00);
			wb(8'h08, 1'b0, 8'h00, {5'h00, i[2:0]});
		end
		sel <= 4'hE;
		wb(8'h08, 1'b1, 8'h00, 8'h00);
		sel <= 4'hF;
		wb(8'h08, 1'b0, 8'h00, 8'h07);
		wb(8'h30, 1'b1, 8'hFF, 8'h00);
		wb(8'h30, 1'b0, 8'h00, 8'h00);
		d = $random(seed);
		wb(8'h04, 1'b1, d, 8'h00);
		wb(8'h04, 1'b0, 8'h00, {4'h0, d[3:0]});
		en = $random(seed);
		pix = $random(seed);
		wb(8'h0C, 1'b1, en, 8'h00);
		wb(8'h0C, 1'b0, 8'h00, en);
		for (i = 0; i < 4; i++) wb({4'h1, i[1:0], 2'b00}, 1'b1, pix, 8'h00);
		wb(8'h1C, 1'b0, 8'h00, pix);
		// low-frequency and Timer1 sources, static and half bias, off, low and medium power, core asleep
		slp <= 1'b1;
		frame(8'h45, 8'h00, 4);
		repeat (40) @(posedge clk);
		check("lit", lit, pix & en);
		check("ladder", ldr, 1);
		frame(8'h05, 8'h0F, 64);
		frame(8'h93, 8'h01, 4);
		check("bias", bm, 1);
		check("bypass", byp, 1);
		check("ladder", ldr, 2);
		slp <= 1'b0;
		// System clock through the fixed divider
		frame(8'hE1, 8'h00, 256);
		check("bias", bm, 2);
		check("bypass", byp, 0);
		check("ladder", ldr, 3);
		// System source halts while the core sleeps
		slp <= 1'b1;
		repeat (2) @(posedge clk);
		d[0] = fc;
		repeat (600) @(posedge clk);
		check("sleep", fc, d[0]);
		wb(8'h00, 1'b1, 8'hC0, 8'h00);
		repeat (3) @(posedge clk);
		check("ladder", ldr, 0);
		summarize;
	end
endmodule
bind lcdcfg_top lcdcfg_chk chk_u (.CLK(CLK), .ARST_N(ARST_N), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .PORT_OUT(PORT_OUT), .PIN_OUT(PIN_OUT), .SEG_FUNC(SEG_FUNC),
	.SEG_OUT(SEG_OUT), .COM_OUT(COM_OUT), .CONTRAST_CODE(CONTRAST_CODE),
	.CONTRAST_SHORT(CONTRAST_SHORT), .LADDER_PWR(LADDER_PWR),
	.LADDER_MID_BYPASS(LADDER_MID_BYPASS), .BIAS_MODE(BIAS_MODE));
